// ===== gap_rx_consts.svh
// constants for the gap-coded write receiver: frame layout, interval windows, timing
// assumes it is included by bare name from each design file that needs it
`ifndef GAP_RX_CONSTS_SVH
`define GAP_RX_CONSTS_SVH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define OPCODE_WRITE 2'h2
`define DATA_BITS 32
`define ADDR_BITS 4
`define FRAME_BITS 6'h26
`define BIT_CNT_SAT 6'h27

// ----------------------------------------
// interval windows in field clock periods
// ----------------------------------------
`define IVL_FIRST 7'h01
`define ZERO_MIN 7'h10
`define ZERO_MAX 7'h1F
`define ONE_MIN 7'h30
`define ONE_MAX 7'h3F
`define IVL_TIMEOUT 7'h40
`define IVL_SAT 7'h7F

// ----------------------------------------
// timing and buffering
// ----------------------------------------
`define PROG_TIME_US 16000
`define CLK_MHZ 100
`define FIFO_DEPTH 16

`endif

// ===== gap_rx_pkg.sv
// types shared by the gap-coded write receiver
// assumes nothing of its surroundings
package gap_rx_pkg;

    // ----------------------------------------
    // decoded link symbols
    // ----------------------------------------
    typedef enum logic [2:0] {
        SYM_START,
        SYM_ZERO,
        SYM_ONE,
        SYM_ERR,
        SYM_END
    } symbol_type;

    // ----------------------------------------
    // frame parser states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_READ,
        ST_FRAME,
        ST_PROG,
        ST_FLUSH
    } parse_state_type;

endpackage

// ===== sym_fifo.sv
// first-in first-out buffer for decoded symbols, valid/ready on both sides
// assumes a single clock and an active-low asynchronous reset
`timescale 1ns/1ps

module sym_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store_reg [DEPTH]; // word storage
    logic [AW-1:0] wr_ptr_reg; // next slot to fill
    logic [AW-1:0] rd_ptr_reg; // oldest word
    logic [AW:0] fill_reg; // words held
    logic push;
    logic pop;

    // advance a pointer, wrapping at the depth
    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // ----------------------------------------
    // handshake
    // ----------------------------------------
    assign in_ready_o = (fill_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (fill_reg != '0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = store_reg[rd_ptr_reg];

    // storage write, no reset on the array
    always_ff @(posedge clk_i) begin
        if (push) begin
            store_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= next_ptr(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= next_ptr(rd_ptr_reg);
            end
            if (push && !pop) begin
                fill_reg <= fill_reg + (AW+1)'(1);
            end else if (pop && !push) begin
                fill_reg <= fill_reg - (AW+1)'(1);
            end
        end
    end

endmodule // sym_fifo

// ===== block_mem.sv
// block store: one word per block, written whole, read data from a register
// assumes writes and reads on one clock; the array itself holds no reset value
`timescale 1ns/1ps

module block_mem #(
    parameter int AW = 4,
    parameter int DW = 32
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);

    logic [DW-1:0] cell_reg [2**AW]; // block contents

    // whole-block write
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            cell_reg[waddr_i] <= wdata_i;
        end
    end

    // registered read port
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= cell_reg[raddr_i];
        end
    end

endmodule // block_mem

// ===== gap_write_rx.sv
// gap-coded write receiver: interval decoding on the field clock, frame parsing
// and block programming on the system clock
// assumes gap_i comes from an analog gap detector, asynchronous to both clocks
`timescale 1ns/1ps
`include "gap_rx_consts.svh"

module gap_write_rx
    import gap_rx_pkg::*;
#(
    parameter int DATA_W = `DATA_BITS,
    parameter int ADDR_W = `ADDR_BITS,
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic link_clk_i,
    input wire logic gap_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o,
    output logic read_mode_o,
    output logic prog_busy_o,
    output logic prog_done_o,
    output logic frame_error_o,
    output logic write_strobe_o,
    output logic [ADDR_W-1:0] write_addr_o,
    output logic [DATA_W-1:0] write_data_o
);
    localparam int FRAME_W = 2 + DATA_W + ADDR_W;
    // true when an interval count lies inside a window
    function automatic logic in_window(input logic [6:0] c, input logic [6:0] lo,
                                       input logic [6:0] hi);
        in_window = (c >= lo) && (c <= hi);
    endfunction
    // ----------------------------------------
    // link domain: reset release and gap detection
    // ----------------------------------------
    logic lrst_s1_reg; // reset release stage one
    logic link_rst_n; // link domain reset, released on link clock
    logic gap_s1_reg; // gap synchroniser stage one
    logic gap_s2_reg; // gap synchroniser stage two
    logic gap_d_reg; // delayed gap for edge detection
    logic gap_edge; // one link cycle at each detected gap
    logic [6:0] cnt_reg; // field cycles since the last gap
    logic in_frame_reg; // a start gap has been seen
    symbol_type sym_reg; // last decoded symbol, held for the crossing
    logic sym_tgl_reg; // flips once per new symbol
    logic zero_hit; // interval in the zero window
    logic one_hit; // interval in the one window
    // reset asserts at once and releases on the link clock
    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lrst_s1_reg <= 1'b0;
            link_rst_n <= 1'b0;
        end else begin
            lrst_s1_reg <= 1'b1;
            link_rst_n <= lrst_s1_reg;
        end
    end
    // two-stage gap synchroniser plus edge delay
    always_ff @(posedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            gap_s1_reg <= 1'b0;
            gap_s2_reg <= 1'b0;
            gap_d_reg <= 1'b0;
        end else begin
            gap_s1_reg <= gap_i;
            gap_s2_reg <= gap_s1_reg;
            gap_d_reg <= gap_s2_reg;
        end
    end
    assign gap_edge = gap_s2_reg & ~gap_d_reg;
    assign zero_hit = in_window(cnt_reg, `ZERO_MIN, `ZERO_MAX);
    assign one_hit = in_window(cnt_reg, `ONE_MIN, `ONE_MAX);
    // interval counter, restarted by each gap and saturating
    always_ff @(posedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cnt_reg <= `IVL_SAT;
        end else if (gap_edge) begin
            cnt_reg <= `IVL_FIRST;
        end else if (cnt_reg != `IVL_SAT) begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end
    // interval decoder, one symbol per gap or timeout
    always_ff @(posedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            in_frame_reg <= 1'b0;
            sym_reg <= SYM_START;
            sym_tgl_reg <= 1'b0;
        end else if (gap_edge) begin
            sym_tgl_reg <= ~sym_tgl_reg;
            if (!in_frame_reg) begin
                // start gap opens a frame
                sym_reg <= SYM_START;
                in_frame_reg <= 1'b1;
            end else if (zero_hit) begin
                sym_reg <= SYM_ZERO;
            end else if (one_hit) begin
                sym_reg <= SYM_ONE;
            end else begin
                // out-of-window interval ends the frame
                sym_reg <= SYM_ERR;
                in_frame_reg <= 1'b0;
            end
        end else if (in_frame_reg && cnt_reg == `IVL_TIMEOUT) begin
            // no further gap: the frame is over
            sym_reg <= SYM_END;
            sym_tgl_reg <= ~sym_tgl_reg;
            in_frame_reg <= 1'b0;
        end
    end
    count_restart_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
        gap_edge ##1 !gap_edge [*3] |-> cnt_reg == 7'h03) else $error("counter not restarted");
    zero_window_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
        gap_edge && in_frame_reg && cnt_reg >= 7'h10 && cnt_reg <= 7'h1F
        |=> sym_reg == SYM_ZERO && sym_tgl_reg != $past(sym_tgl_reg))
        else $error("zero interval not decoded");
    one_window_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
        gap_edge && in_frame_reg && cnt_reg >= 7'h30 && cnt_reg <= 7'h3F
        |=> sym_reg == SYM_ONE && sym_tgl_reg != $past(sym_tgl_reg))
        else $error("one interval not decoded");
    bad_interval_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
        gap_edge && in_frame_reg && (cnt_reg < 7'h10 || (cnt_reg > 7'h1F && cnt_reg < 7'h30)
        || cnt_reg > 7'h3F) |=> sym_reg == SYM_ERR && !in_frame_reg)
        else $error("invalid interval not flagged");
    // ----------------------------------------
    // crossing into the system domain and buffering
    // ----------------------------------------
    logic tgl_s1_reg; // toggle synchroniser stage one
    logic tgl_s2_reg; // toggle synchroniser stage two
    logic tgl_seen_reg; // toggle value already taken
    logic push_valid; // a new symbol waits to be buffered
    logic push_ready; // buffer has room
    logic pop_valid; // buffered symbol available
    logic pop_ready; // parser takes symbols
    logic [2:0] pop_data; // raw buffered symbol
    symbol_type pop_sym; // buffered symbol
    logic pop; // symbol taken this cycle
    // two-stage toggle synchroniser
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
        end else begin
            tgl_s1_reg <= sym_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
        end
    end
    assign push_valid = (tgl_s2_reg != tgl_seen_reg);
    // symbol stays pending while the buffer is full
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tgl_seen_reg <= 1'b0;
        end else if (push_valid && push_ready) begin
            tgl_seen_reg <= tgl_s2_reg;
        end
    end
    sym_fifo #(
        .WIDTH(3),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(sym_reg),
        .out_valid_o(pop_valid),
        .out_ready_i(pop_ready),
        .out_data_o(pop_data)
    );
    assign pop_sym = symbol_type'(pop_data);
    assign pop = pop_valid & pop_ready;
    // ----------------------------------------
    // frame parser
    // ----------------------------------------
    parse_state_type state_reg; // parser state
    logic [5:0] bit_cnt_reg; // bits collected, saturating
    logic [FRAME_W-1:0] frame_sr_reg; // opcode, data, address, first bit highest
    logic [1:0] op_field; // received opcode
    logic [DATA_W-1:0] data_field; // received data word
    logic [ADDR_W-1:0] addr_field; // received block address
    logic frame_ok; // count and opcode both right
    logic end_seen; // frame end taken this cycle
    logic prog_start; // good frame, start programming
    logic [31:0] prog_cnt_reg; // programming cycles left
    logic prog_over; // programming time elapsed
    // buffer stalls only while a block is programmed
    assign pop_ready = (state_reg != ST_PROG);
    assign op_field = frame_sr_reg[FRAME_W-1 -: 2];
    assign data_field = frame_sr_reg[ADDR_W +: DATA_W];
    assign addr_field = frame_sr_reg[ADDR_W-1:0];
    assign frame_ok = (bit_cnt_reg == `FRAME_BITS) && (op_field == `OPCODE_WRITE);
    assign end_seen = pop && (state_reg == ST_FRAME) && (pop_sym == SYM_END);
    assign prog_start = end_seen && frame_ok;
    assign prog_over = (state_reg == ST_PROG) && (prog_cnt_reg == 32'h0000_0000);
    // parser state sequence
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_READ;
        end else begin
            case (state_reg)
                ST_READ: begin
                    if (pop && pop_sym == SYM_START) begin
                        state_reg <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (pop && pop_sym == SYM_ERR) begin
                        state_reg <= ST_READ;
                    end else if (end_seen) begin
                        state_reg <= frame_ok ? ST_PROG : ST_READ;
                    end
                end
                ST_PROG: begin
                    if (prog_over) begin
                        state_reg <= ST_FLUSH;
                    end
                end
                ST_FLUSH: begin
                    // drop what arrived while busy
                    if (!pop_valid) begin
                        state_reg <= ST_READ;
                    end
                end
                default: begin
                    state_reg <= ST_READ;
                end
            endcase
        end
    end
    // bit collection in arrival order
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt_reg <= 6'h00;
            frame_sr_reg <= '0;
        end else if (pop && state_reg == ST_READ && pop_sym == SYM_START) begin
            bit_cnt_reg <= 6'h00;
            frame_sr_reg <= '0;
        end else if (pop && state_reg == ST_FRAME && (pop_sym == SYM_ZERO || pop_sym == SYM_ONE)) begin
            frame_sr_reg <= {frame_sr_reg[FRAME_W-2:0], pop_sym == SYM_ONE};
            if (bit_cnt_reg != `BIT_CNT_SAT) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
        end
    end
    // programming timer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prog_cnt_reg <= 32'h0000_0000;
        end else if (prog_start) begin
            prog_cnt_reg <= 32'(PROG_CYCLES - 1);
        end else if (state_reg == ST_PROG && prog_cnt_reg != 32'h0000_0000) begin
            prog_cnt_reg <= prog_cnt_reg - 32'h0000_0001;
        end
    end
    // ----------------------------------------
    // block write and status outputs
    // ----------------------------------------
    // write port registers, loaded only by a good frame
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            write_strobe_o <= 1'b0;
            write_addr_o <= '0;
            write_data_o <= '0;
        end else begin
            write_strobe_o <= prog_start;
            if (prog_start) begin
                write_addr_o <= addr_field;
                write_data_o <= data_field;
            end
        end
    end
    block_mem #(
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_mem (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .we_i(write_strobe_o),
        .waddr_i(write_addr_o),
        .wdata_i(write_data_o),
        .raddr_i(rd_addr_i),
        .rdata_o(rd_data_o)
    );
    // mode and event flags
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            read_mode_o <= 1'b1;
            prog_busy_o <= 1'b0;
            prog_done_o <= 1'b0;
            frame_error_o <= 1'b0;
        end else begin
            read_mode_o <= (state_reg == ST_READ);
            prog_busy_o <= (state_reg == ST_PROG);
            prog_done_o <= prog_over;
            frame_error_o <= (pop && state_reg == ST_FRAME && pop_sym == SYM_ERR)
                             || (end_seen && !frame_ok);
        end
    end
    opcode_ok_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        write_strobe_o |-> $past(op_field) == 2'h2)
        else $error("block written with wrong opcode");
    data_word_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        write_strobe_o |-> write_data_o == $past(data_field))
        else $error("written word differs from received data");
    addr_select_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        write_strobe_o |-> write_addr_o == $past(addr_field))
        else $error("written block differs from received address");
    bit_total_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        write_strobe_o |-> $past(bit_cnt_reg) == 6'h26 && $past(end_seen))
        else $error("block written without exact bit count");
    error_exit_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        pop && state_reg == ST_FRAME && pop_sym == SYM_ERR |=> state_reg == ST_READ ##1 read_mode_o)
        else $error("error interval did not return to read mode");
    read_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_reg == ST_READ |=> read_mode_o && !prog_busy_o)
        else $error("read mode not shown");
    prog_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        prog_start |=> state_reg == ST_PROG ##1 prog_busy_o [*8])
        else $error("programming ended too early");
    bad_frame_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        end_seen && !frame_ok |=> !write_strobe_o && state_reg == ST_READ && frame_error_o)
        else $error("bad frame altered memory or kept write mode");
endmodule // gap_write_rx

// ===== base_station.sv
// base station model: writes frames to the receiver by gapping the field
// assumes the field clock runs free and the caller waits for each task to return
`timescale 1ns/1ps

module base_station (
    input wire logic link_clk_i,
    output logic gap_o
);
    // ----------------------------------------
    // field gaps
    // ----------------------------------------
    initial gap_o = 1'b0;

    // gap of three field cycles, next gap n cycles after this one
    task automatic interval(input int n);
        @(posedge link_clk_i);
        gap_o <= 1'b1;
        repeat (3) @(posedge link_clk_i);
        gap_o <= 1'b0;
        repeat (n - 4) @(posedge link_clk_i);
    endtask

    // interval length for one bit: window edges first, then random inside
    function automatic int pick(input logic b, input int i);
        if (i % 3 == 0) return b ? 48 : 16;
        if (i % 3 == 1) return b ? 63 : 31;
        return b ? $urandom_range(63, 48) : $urandom_range(31, 16);
    endfunction

    // start gap, nb bits msb first, optional bad interval, closing gap, silence
    task automatic send_frame(input logic [1:0] op, input logic [31:0] d,
                              input logic [3:0] a, input int nb, input int bad_at,
                              input int bad_cnt);
        logic [38:0] f;
        f = {op, d, a, 1'b0};
        for (int i = 0; i < nb; i++) begin
            if (i == bad_at) begin
                interval(bad_cnt);
                break;
            end
            interval(pick(f[38-i], i));
        end
        interval(4);
        repeat (80) @(posedge link_clk_i);
    endtask
endmodule // base_station

// ===== gap_write_rx_test.sv
// self-checking bench for the gap-coded write receiver
// assumes the base station model drives the gap line from the field clock
`timescale 1ns/1ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: %s", $time, m); end end

module gap_write_rx_test;
    import gap_rx_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int PROG_N = 50; // shortened programming time
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic gap_i;
    logic [3:0] rd_addr_i = 4'h0;
    logic [31:0] rd_data_o, write_data_o, d0;
    logic [3:0] write_addr_o, a0;
    logic read_mode_o, prog_busy_o, prog_done_o, frame_error_o, write_strobe_o;
    typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d;} note_type;
    note_type notes[$]; // expected results, oldest first
    note_type got;
    int fail_count = 0;
    int total_checks = 0;
    int busy_cnt = 0; // cycles with programming busy

    always #5 clk_i = ~clk_i;
    initial begin
        #13;
        forever #40 link_clk_i = ~link_clk_i;
    end

    gap_write_rx #(.PROG_CYCLES(PROG_N)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .link_clk_i(link_clk_i), .gap_i(gap_i), .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o), .read_mode_o(read_mode_o), .prog_busy_o(prog_busy_o),
        .prog_done_o(prog_done_o), .frame_error_o(frame_error_o),
        .write_strobe_o(write_strobe_o), .write_addr_o(write_addr_o),
        .write_data_o(write_data_o));
    base_station station (.link_clk_i(link_clk_i), .gap_o(gap_i));

    // ----------------------------------------
    // monitor: each result against the oldest note
    // ----------------------------------------
    always @(negedge clk_i) begin
        if (prog_busy_o === 1'b1) busy_cnt++;
        if (write_strobe_o === 1'b1 || frame_error_o === 1'b1) begin
            if (notes.size() == 0) `CHK(1'b1, 1'b0, "unexpected result")
            else begin
                got = notes.pop_front();
                `CHK(write_strobe_o, got.wr, "write versus error")
                if (got.wr) begin
                    `CHK(write_addr_o, got.a, "block address")
                    `CHK(write_data_o, got.d, "data word")
                    `CHK(read_mode_o, 1'b0, "read mode in frame")
                end
            end
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // frame, then result drained, read mode back, first block a0 checked against d0
    task automatic frame(input logic [1:0] op, input logic [31:0] d, input logic [3:0] a,
                         input int nb, input int bad_at, input int bad_cnt);
        int i;
        notes.push_back('{(op == 2'h2 && nb == 38 && bad_at > 38), a, d});
        busy_cnt = 0;
        station.send_frame(op, d, a, nb, bad_at, bad_cnt);
        for (i = 0; i < 2000 && notes.size() != 0; i++) @(negedge clk_i);
        if (notes.size() != 0) begin
            fail_count++;
            close_out();
        end
        `CHK(read_mode_o, 1'b1, "read mode after frame")
        @(posedge clk_i);
        rd_addr_i <= a0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        `CHK(rd_data_o, d0, "stored block")
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h9BDD));
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(negedge clk_i);
        `CHK(read_mode_o, 1'b1, "read mode after reset")
        `CHK(prog_busy_o, 1'b0, "busy after reset")
        repeat (5) @(posedge link_clk_i);
        // two good frames to different blocks
        a0 = 4'($urandom);
        d0 = $urandom;
        frame(2'h2, d0, a0, 38, 99, 0);
        `CHK((busy_cnt >= PROG_N - 1 && busy_cnt <= PROG_N + 1), 1'b1, "busy time")
        frame(2'h2, $urandom, a0 ^ 4'hF, 38, 99, 0);
        // bad frames aimed at the first block must leave it alone
        frame(2'h1, $urandom, a0, 38, 99, 0);
        frame(2'h2, $urandom, a0, 37, 99, 0);
        frame(2'h2, $urandom, a0, 39, 99, 0);
        frame(2'h2, $urandom, a0, 38, 0, 15);
        frame(2'h2, $urandom, a0, 38, 5, 32);
        frame(2'h2, $urandom, a0, 38, 9, 47);
        frame(2'h2, $urandom, a0, 38, 3, 64);
        close_out();
    end
endmodule // gap_write_rx_test
